// ### bench/tb.sv
`timescale 1ns/1ps
module tb;
  import tmr8_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, pin_out, pin_oe_n, e, mt;
  logic [7:0] paddr, m_cnt, m_cmp, m_buf;
  logic [31:0] pwdata, prdata, r;
  logic [1:0] m_act, m_mode, md, ac;
  logic [2:0] m_cs;
  logic [2:0] cs_r;
  logic [9:0] m_p;
  // Divide factor for each clock source select value; entry zero is unused.
  int presc_tab [8] = '{1, 1, 8, 32, 64, 128, 256, 1024};
  logic m_wo, m_mf, m_ovf, m_blk, m_dir, m_port;
  tmr8_flags_s flags;
  int mismatches, n_tests;

  tmr8_compare dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .flags(flags), .pin_out(pin_out), .pin_oe_n(pin_oe_n));

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  //////////////////////////////////////////////////////////////////////////////
  function automatic logic act_f(input logic [1:0] a, input logic w);
    return a == TMR8_ACT_TOGGLE ? ~w : a == TMR8_ACT_CLEAR ? 1'b0 : a == TMR8_ACT_SET ? 1'b1 : w;
  endfunction : act_f

  // The model sees each edge with the values that stood just before it.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      {m_cnt, m_cmp, m_buf, m_act, m_mode, m_cs} = '0;
      {m_wo, m_mf, m_ovf, m_blk, m_dir, m_port} = '0;
      m_p = '0;
    end
    else
    begin
      if (psel && penable && pwrite && pready && paddr == TMR8_OFF_FLAGS)
        {m_ovf, m_mf} = {m_ovf, m_mf} & ~pwdata[1:0];
      if (m_cs != TMR8_CLK_STOP && m_p % presc_tab[m_cs] == presc_tab[m_cs] - 1)
      begin
        mt = m_cnt == m_cmp && !m_blk;
        if (mt)
        begin
          m_mf = 1'b1;
          m_wo = act_f(m_act, m_wo);
        end
        if (m_cnt == TMR8_MAX)
        begin
          m_ovf = 1'b1;
          if (m_mode[0])
            m_cmp = m_buf;
        end
        m_blk = 1'b0;
        m_cnt = (mt && m_mode == TMR8_MODE_CLEAR_ON_MATCH) ? TMR8_BOTTOM : m_cnt + 8'h01;
      end
      m_p = m_p + 10'h001;
      if (psel && penable && pwrite && pready)
        case (paddr)
          TMR8_OFF_CTRL:
          begin
            if (pwdata[7] && !m_mode[0])
              m_wo = act_f(m_act, m_wo);
            {m_act, m_mode, m_cs} = pwdata[6:0];
          end
          TMR8_OFF_COUNT:
          begin
            m_cnt = pwdata[7:0];
            m_blk = 1'b1;
          end
          TMR8_OFF_COMPARE:
          begin
            m_buf = pwdata[7:0];
            if (!m_mode[0])
              m_cmp = pwdata[7:0];
          end
          TMR8_OFF_PIN: {m_port, m_dir} = pwdata[1:0];
          default: ;
        endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    if (mismatches == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Leaves the request standing so that a following transfer may start at once.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && t < 20)
    begin
      t++;
      @(posedge pclk);
    end
    if (t >= 20)
      mismatches++;
    r = prdata;
    e = pslverr;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h00000000);
  endtask : rd

  task automatic idle(input int n);
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (n) @(posedge pclk);
  endtask : idle

  task automatic check_all;
    idle(3);
    rd(TMR8_OFF_STATUS);
    chk(r, {15'h0000, m_wo, m_cmp, m_cnt});
    rd(TMR8_OFF_FLAGS);
    chk(r, {30'h0, m_ovf, m_mf});
    rd(TMR8_OFF_COMPARE);
    chk(r, {24'h000000, m_mode[0] ? m_buf : m_cmp});
    idle(2);
    chk({30'h0, flags}, {30'h0, m_ovf, m_mf});
    chk({30'h0, pin_out, pin_oe_n}, {30'h0, m_act != 2'h0 ? m_wo : m_port, !m_dir});
  endtask : check_all

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #600000;
    mismatches++;
    report_and_stop;
  end

  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    void'($urandom(57683));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check_all;
    rd(TMR8_OFF_CTRL);
    chk(r, 32'h00000000);
    rd(8'h18);
    chk(r, 32'h00000000);
    chk({31'h0, e}, 32'h00000001);
    // Forced compares in every mode and action; the output state is set before the pin drives.
    wr(TMR8_OFF_CTRL, {24'h0, 1'b0, TMR8_ACT_CLEAR, TMR8_MODE_NORMAL, 3'h0});
    wr(TMR8_OFF_CTRL, {24'h0, 1'b1, TMR8_ACT_CLEAR, TMR8_MODE_NORMAL, 3'h0});
    wr(TMR8_OFF_PIN, 32'h00000003);
    for (int fm = 0; fm < 4; fm++)
      for (int fa = 0; fa < 4; fa++)
      begin
        wr(TMR8_OFF_CTRL, {24'h0, 1'b0, fa[1:0], fm[1:0], 3'h0});
        wr(TMR8_OFF_CTRL, {24'h0, 1'b1, fa[1:0], fm[1:0], 3'h0});
        check_all;
      end
    wr(TMR8_OFF_COMPARE, 32'h0000005A);
    check_all;
    // Counter writes equal to the compare value, stopped and running, raise no match.
    wr(TMR8_OFF_CTRL, {24'h0, 1'b0, TMR8_ACT_TOGGLE, TMR8_MODE_CLEAR_ON_MATCH, 3'h0});
    wr(TMR8_OFF_COMPARE, 32'h00000040);
    wr(TMR8_OFF_COUNT, 32'h00000040);
    wr(TMR8_OFF_FLAGS, 32'h00000003);
    wr(TMR8_OFF_CTRL, {24'h0, 1'b0, TMR8_ACT_TOGGLE, TMR8_MODE_CLEAR_ON_MATCH, 3'h1});
    wr(TMR8_OFF_COUNT, 32'h00000040);
    wr(TMR8_OFF_CTRL, {24'h0, 1'b0, TMR8_ACT_TOGGLE, TMR8_MODE_CLEAR_ON_MATCH, 3'h0});
    check_all;
    chk({31'h0, flags.compare_match_flag}, 32'h00000000);
    // The buffered compare value reaches the comparator only when the counter passes its maximum.
    wr(TMR8_OFF_CTRL, {24'h0, 1'b0, TMR8_ACT_NONE, TMR8_MODE_FAST_PWM, 3'h0});
    wr(TMR8_OFF_COMPARE, 32'h00000033);
    wr(TMR8_OFF_COUNT, 32'h000000FD);
    wr(TMR8_OFF_CTRL, {24'h0, 1'b0, TMR8_ACT_NONE, TMR8_MODE_FAST_PWM, 3'h1});
    idle(5);
    wr(TMR8_OFF_CTRL, {24'h0, 1'b0, TMR8_ACT_NONE, TMR8_MODE_FAST_PWM, 3'h0});
    check_all;
    // Random runs in normal and clear-on-match modes.
    for (int i = 0; i < 40; i++)
    begin
      md = ($urandom % 2) ? TMR8_MODE_CLEAR_ON_MATCH : TMR8_MODE_NORMAL;
      ac = 2'($urandom);
      cs_r = 3'($urandom % 7 + 1);
      wr(TMR8_OFF_CTRL, {24'h0, 1'b0, ac, md, 3'h0});
      wr(TMR8_OFF_COMPARE, $urandom % 255);
      wr(TMR8_OFF_COUNT, $urandom);
      wr(TMR8_OFF_FLAGS, 32'h00000003);
      wr(TMR8_OFF_PIN, $urandom);
      wr(TMR8_OFF_CTRL, {24'h0, 1'b0, ac, md, cs_r});
      idle($urandom % 300 + 1);
      if (m_cnt < 8'hF0)
        wr(TMR8_OFF_COUNT, $urandom);
      idle(3);
      wr(TMR8_OFF_CTRL, {24'h0, 1'b0, ac, md, 3'h0});
      check_all;
    end
    report_and_stop;
  end
endmodule : tb

// ### rtl/tmr8_compare.sv
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////////////////////////
// Contract
// RULE1: Buffer compare value only in PWM modes.
// RULE2: Buffered value loads at top or bottom.
// RULE3: CPU reaches buffer or active compare register.
// RULE4: Force strobe updates output, no flag, no clear. Code ignores the strobe in both PWM modes.
// RULE5: Counter write blocks next timer cycle's match.
// RULE6: Software sets output state before enabling pin.
// RULE7: Output state kept across mode changes.
// RULE8: Action bits unbuffered, effective at next event.
// RULE9: Action bits pick match effect and pin source.
// RULE10: Normal mode wraps, overflow set entering zero.
// RULE11: Counting only sets overflow; software clears it.
// RULE12: Counter writable anytime in normal mode.
// RULE13: Mode two clears counter on compare match.
// RULE14: Match flag raised at each top in mode two.
// RULE15: Compare below count waits for full wrap.
// RULE16: Action one toggles output on each match.
// RULE17: Output reaches pin only when direction output.
// RULE18: Prescale 1,8,32,64,128,256,1024 selectable.
// RULE19: Mode two overflow set passing max to zero.
// RULE20: Match flag set next timer cycle; write-one clears.
// RULE21: CPU counter write beats clear or count.
// RULE22: Clock select zero stops counter, still accessible.
// RULE23: Normal mode increments by one, wraps freely.
//////////////////////////////////////////////////////////////////////////////////////////////////
module tmr8_compare (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output tmr8_pkg::tmr8_flags_s flags,
  output logic pin_out,
  output logic pin_oe_n
);
  import tmr8_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Helpers.

  function automatic logic is_pwm(input logic [1:0] mode);
    is_pwm = (mode == TMR8_MODE_PHASE_PWM) || (mode == TMR8_MODE_FAST_PWM);
  endfunction : is_pwm

  function automatic logic apply_action(input logic [1:0] act, input logic cur);
    case (act)
      TMR8_ACT_TOGGLE: apply_action = !cur;
      TMR8_ACT_CLEAR: apply_action = 1'b0;
      TMR8_ACT_SET: apply_action = 1'b1;
      default: apply_action = cur;
    endcase
  endfunction : apply_action

  // Prescaler mask for divide factors 1, 8, 32, 64, 128, 256 and 1024.
  function automatic logic [TMR8_PRESC_W-1:0] presc_mask(input logic [2:0] sel);
    case (sel)
      3'h2: presc_mask = 10'h007;
      3'h3: presc_mask = 10'h01F;
      3'h4: presc_mask = 10'h03F;
      3'h5: presc_mask = 10'h07F;
      3'h6: presc_mask = 10'h0FF;
      3'h7: presc_mask = 10'h3FF;
      default: presc_mask = 10'h000;
    endcase
  endfunction : presc_mask

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // State.

  tmr8_ctrl_s ctrl, next_ctrl;
  logic [7:0] count, next_count;
  logic [7:0] compare_value, next_compare_value;
  logic [7:0] compare_buf, next_compare_buf;
  logic compare_match_flag, next_compare_match_flag;
  logic overflow_flag, next_overflow_flag;
  logic waveform_output, next_waveform_output;
  logic blocked, next_blocked;
  logic pin_dir, next_pin_dir;
  logic port_data, next_port_data;
  logic [TMR8_PRESC_W-1:0] presc, next_presc;
  logic next_pin_out, next_pin_oe_n;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;

  logic access, wr, setup;
  logic tick, pwm, hit, match;
  logic ctrl_wr, count_wr, compare_wr, flags_wr, pin_wr, force_wr;

  assign setup = psel && !penable;
  assign access = psel && penable && pready;
  assign wr = access && pwrite && !pslverr;
  assign ctrl_wr = wr && (paddr == TMR8_OFF_CTRL);
  assign count_wr = wr && (paddr == TMR8_OFF_COUNT);
  assign compare_wr = wr && (paddr == TMR8_OFF_COMPARE);
  assign flags_wr = wr && (paddr == TMR8_OFF_FLAGS);
  assign pin_wr = wr && (paddr == TMR8_OFF_PIN);
  assign force_wr = ctrl_wr && pwdata[TMR8_CTRL_FORCE_BIT];

  // Timer clock enable from the free-running prescaler.
  assign tick = (ctrl.clock_source_select != TMR8_CLK_STOP) && // RULE22
    ((presc & presc_mask(ctrl.clock_source_select)) == presc_mask(ctrl.clock_source_select)); // RULE18
  assign pwm = is_pwm(ctrl.waveform_mode_select);
  assign hit = (count == compare_value);
  assign match = tick && hit && !blocked; // RULE5

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Timer core.

  always_comb
  begin
    next_ctrl = ctrl;
    next_count = count;
    next_compare_value = compare_value;
    next_compare_buf = compare_buf;
    next_compare_match_flag = compare_match_flag;
    next_overflow_flag = overflow_flag;
    next_waveform_output = waveform_output;
    next_blocked = blocked;
    next_pin_dir = pin_dir;
    next_port_data = port_data;
    next_presc = TMR8_PRESC_W'(presc + 1'b1);

    if (tick)
    begin
      next_blocked = 1'b0;
      if (ctrl.waveform_mode_select == TMR8_MODE_CLEAR_ON_MATCH && match)
      begin
        next_count = TMR8_BOTTOM; // RULE13
      end
      else
      begin
        next_count = 8'(count + 1'b1); // RULE23 RULE15
      end
      if (count == TMR8_MAX)
      begin
        next_overflow_flag = 1'b1; // RULE10 RULE19
        if (pwm)
        begin
          next_compare_value = compare_buf; // RULE2
        end
        if (ctrl.waveform_mode_select == TMR8_MODE_FAST_PWM && ctrl.compare_output_action[1])
        begin
          next_waveform_output = (ctrl.compare_output_action == TMR8_ACT_CLEAR);
        end
      end
      if (match)
      begin
        next_compare_match_flag = 1'b1; // RULE20 RULE14
        next_waveform_output = apply_action(ctrl.compare_output_action, waveform_output); // RULE16 RULE9 RULE8
      end
    end

    if (force_wr && !pwm)
    begin
      next_waveform_output = apply_action(ctrl.compare_output_action, waveform_output); // RULE4
    end
    if (ctrl_wr)
    begin
      // The output state register is untouched by a mode change.
      next_ctrl = tmr8_ctrl_s'(pwdata[6:0]); // RULE7
    end
    if (count_wr)
    begin
      next_count = pwdata[7:0]; // RULE21 RULE12
      next_blocked = 1'b1; // RULE5
    end
    if (compare_wr)
    begin
      next_compare_buf = pwdata[7:0]; // RULE1
      if (!pwm)
      begin
        next_compare_value = pwdata[7:0]; // RULE3
      end
    end
    if (flags_wr)
    begin
      // A hardware set in the same cycle wins over the write-one clear.
      next_compare_match_flag = next_compare_match_flag &
        !(pwdata[TMR8_FLAG_MATCH_BIT] && !(tick && match)); // RULE20
      next_overflow_flag = next_overflow_flag &
        !(pwdata[TMR8_FLAG_OVF_BIT] && !(tick && count == TMR8_MAX)); // RULE11
    end
    if (pin_wr)
    begin
      next_pin_dir = pwdata[TMR8_PIN_DIR_BIT];
      next_port_data = pwdata[TMR8_PIN_PORT_BIT];
    end

    if (ctrl.compare_output_action != TMR8_ACT_NONE)
    begin
      next_pin_out = waveform_output; // RULE9
    end
    else
    begin
      next_pin_out = port_data;
    end
    next_pin_oe_n = !pin_dir; // RULE17
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl <= TMR8_CTRL_RST;
      count <= TMR8_COUNT_RST;
      compare_value <= TMR8_COMPARE_RST;
      compare_buf <= TMR8_COMPARE_RST;
      compare_match_flag <= 1'b0;
      overflow_flag <= 1'b0;
      waveform_output <= 1'b0;
      blocked <= 1'b0;
      pin_dir <= 1'b0;
      port_data <= 1'b0;
      presc <= '0;
      pin_out <= 1'b0;
      pin_oe_n <= 1'b1;
      flags <= '0;
    end
    else
    begin
      ctrl <= next_ctrl;
      count <= next_count;
      compare_value <= next_compare_value;
      compare_buf <= next_compare_buf;
      compare_match_flag <= next_compare_match_flag;
      overflow_flag <= next_overflow_flag;
      waveform_output <= next_waveform_output;
      blocked <= next_blocked;
      pin_dir <= next_pin_dir;
      port_data <= next_port_data;
      presc <= next_presc;
      pin_out <= next_pin_out;
      pin_oe_n <= next_pin_oe_n;
      flags <= '{next_overflow_flag, next_compare_match_flag};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // APB slave: answer prepared in the setup cycle, so every access has no wait state.

  always_comb
  begin
    next_prdata = 32'h00000000;
    next_pready = setup;
    next_pslverr = 1'b0;
    if (setup)
    begin
      if (paddr == TMR8_OFF_CTRL)
      begin
        next_prdata = {24'h0, 1'b0, ctrl};
      end
      else if (paddr == TMR8_OFF_COUNT)
      begin
        next_prdata = {24'h0, count};
      end
      else if (paddr == TMR8_OFF_COMPARE)
      begin
        next_prdata = {24'h0, pwm ? compare_buf : compare_value}; // RULE3
      end
      else if (paddr == TMR8_OFF_FLAGS)
      begin
        next_prdata = {30'h0, overflow_flag, compare_match_flag};
      end
      else if (paddr == TMR8_OFF_PIN)
      begin
        next_prdata = {30'h0, port_data, pin_dir};
      end
      else if (paddr == TMR8_OFF_STATUS)
      begin
        next_prdata = {15'h0, waveform_output, compare_value, count};
      end
      else
      begin
        next_pslverr = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_force_no_flag: assert property ( // RULE4
    (force_wr && !pwm && !tick && !compare_match_flag) |=> !compare_match_flag && $stable(count))
    else $error("Force strobe changed flag or counter.");
  a_count_write_wins: assert property ( // RULE21
    count_wr |=> count == $past(pwdata[7:0]))
    else $error("Counter write lost against counting.");
  a_write_blocks_match: assert property ( // RULE5
    (count_wr ##1 (tick && hit && !compare_match_flag && !flags_wr)) |=> !compare_match_flag)
    else $error("Match not blocked after counter write.");
  a_overflow_on_wrap: assert property ( // RULE10
    (tick && count == TMR8_MAX && !count_wr) |=> overflow_flag && count == TMR8_BOTTOM)
    else $error("Overflow not set on wrap to zero.");
  a_match_clears: assert property ( // RULE13
    (match && ctrl.waveform_mode_select == TMR8_MODE_CLEAR_ON_MATCH && !count_wr)
      |=> count == TMR8_BOTTOM && compare_match_flag)
    else $error("Counter not cleared on compare match.");
  a_normal_increment: assert property ( // RULE23
    (tick && !count_wr && ctrl.waveform_mode_select == TMR8_MODE_NORMAL)
      |=> count == 8'($past(count) + 1'b1))
    else $error("Normal mode did not increment by one.");
  a_stopped_holds: assert property ( // RULE22
    (ctrl.clock_source_select == TMR8_CLK_STOP && !count_wr) [*2] |-> $stable(count))
    else $error("Stopped counter moved.");
  a_match_toggle: assert property ( // RULE16
    (match && !force_wr && ctrl.compare_output_action == TMR8_ACT_TOGGLE
      && ctrl.waveform_mode_select == TMR8_MODE_CLEAR_ON_MATCH)
      |=> waveform_output != $past(waveform_output))
    else $error("Output did not toggle on match.");
  a_direct_compare: assert property ( // RULE3
    (compare_wr && !pwm) |=> compare_value == $past(pwdata[7:0]))
    else $error("Direct compare write not applied.");
  a_pin_direction: assert property ( // RULE17
    !pin_dir |=> pin_oe_n)
    else $error("Pin driven while direction is input.");

  c_clear_mode_match: cover property (match && ctrl.waveform_mode_select == TMR8_MODE_CLEAR_ON_MATCH);
  c_force_toggle: cover property (force_wr && ctrl.compare_output_action == TMR8_ACT_TOGGLE);
  c_buffer_load: cover property (tick && pwm && count == TMR8_MAX && compare_buf != compare_value);
  c_blocked_hit: cover property (tick && hit && blocked);

endmodule : tmr8_compare

// ### rtl/tmr8_pkg.sv
package tmr8_pkg;

  // Register byte offsets on the APB bus.
  localparam logic [7:0] TMR8_OFF_CTRL = 8'h00;
  localparam logic [7:0] TMR8_OFF_COUNT = 8'h04;
  localparam logic [7:0] TMR8_OFF_COMPARE = 8'h08;
  localparam logic [7:0] TMR8_OFF_FLAGS = 8'h0C;
  localparam logic [7:0] TMR8_OFF_PIN = 8'h10;
  localparam logic [7:0] TMR8_OFF_STATUS = 8'h14;

  // Field positions.
  localparam int TMR8_CTRL_FORCE_BIT = 7;
  localparam int TMR8_FLAG_MATCH_BIT = 0;
  localparam int TMR8_FLAG_OVF_BIT = 1;
  localparam int TMR8_PIN_DIR_BIT = 0;
  localparam int TMR8_PIN_PORT_BIT = 1;

  // Counter extremes.
  localparam logic [7:0] TMR8_BOTTOM = 8'h00;
  localparam logic [7:0] TMR8_MAX = 8'hFF;

  // Reset values.
  localparam logic [7:0] TMR8_COUNT_RST = 8'h00;
  localparam logic [7:0] TMR8_COMPARE_RST = 8'h00;

  // Waveform generation modes, encoded as the two mode select bits.
  localparam logic [1:0] TMR8_MODE_NORMAL = 2'h0;
  localparam logic [1:0] TMR8_MODE_PHASE_PWM = 2'h1;
  localparam logic [1:0] TMR8_MODE_CLEAR_ON_MATCH = 2'h2;
  localparam logic [1:0] TMR8_MODE_FAST_PWM = 2'h3;

  // Compare output actions.
  localparam logic [1:0] TMR8_ACT_NONE = 2'h0;
  localparam logic [1:0] TMR8_ACT_TOGGLE = 2'h1;
  localparam logic [1:0] TMR8_ACT_CLEAR = 2'h2;
  localparam logic [1:0] TMR8_ACT_SET = 2'h3;

  // Clock source select value that stops the counter.
  localparam logic [2:0] TMR8_CLK_STOP = 3'h0;
  localparam int TMR8_PRESC_W = 10;

  typedef struct packed {
    logic [1:0] compare_output_action;
    logic [1:0] waveform_mode_select;
    logic [2:0] clock_source_select;
  } tmr8_ctrl_s;

  localparam tmr8_ctrl_s TMR8_CTRL_RST = '{2'h0, 2'h0, 3'h0};

  typedef struct packed {
    logic overflow_flag;
    logic compare_match_flag;
  } tmr8_flags_s;

endpackage : tmr8_pkg
